// ===== inc/eth_dma_consts.vh
// register offsets, field positions, reset values, byte step and margin values and interrupt bits for the dma monitor slice
// What this block does
// RULE1 - buffer monitor register shows the 32-bit transmit buffer read address
// RULE2 - buffer monitor may lag the live read pointer
// RULE3 - descriptor monitor shows start address of descriptor being fetched
// RULE4 - both monitors reset to zero, read-only, writes ignored
// RULE5 - frame threshold bits 18:16 trigger at field plus one stored frames
// RULE6 - byte threshold bits 2:0 trigger at code*256+256-32, code 7 at 2048-64
// RULE7 - byte threshold equal to fifo size triggers at size minus 64
// RULE8 - flow control asserted when either condition is met
// RULE9 - flow control released when neither condition holds
// RULE10 - software keeps byte threshold code at or below fifo size code
// RULE11 - notify bit clear: each frame writeback sets the writeback flag
// RULE12 - notify bit set: per-frame writeback completion is not signalled
// RULE13 - reserved bits read zero, software writes zero
// RULE14 - fifo size code selects 256 bytes to 2 kbytes in 256-byte steps
// RULE15 - flow request is a level re-evaluated every clock
`ifndef ETH_DMA_CONSTS_VH
`define ETH_DMA_CONSTS_VH

`define OFS_TX_BUF_MON      8'h00
`define OFS_TX_DESC_MON     8'h04
`define OFS_ALERT_THRESH    8'h08
`define OFS_TX_INT_SET      8'h0C
`define OFS_FIFO_SIZE       8'h10
`define OFS_IRQ_STATUS      8'h14
`define OFS_IRQ_MASK        8'h18

`define FRAME_THR_LSB       16
`define FRAME_THR_MSB       18
`define BYTE_THR_LSB        0
`define BYTE_THR_MSB        2
`define NOTIFY_DIS_BIT      0

`define THRESH_RESET        32'h00070007
`define FIFO_SIZE_RESET     3'h7
`define BYTE_STEP           12'h100
`define BYTE_MARGIN_SMALL   12'h020
`define BYTE_MARGIN_LARGE   12'h040

`define IRQ_WB_BIT          0
`define IRQ_FLOW_BIT        1
`define IRQ_WIDTH           2

`endif

// ===== hdl/flow_threshold_calc.v
// byte-level threshold computation for the receive overflow alert
`timescale 1ns/1ps
`include "eth_dma_consts.vh"

module flow_threshold_calc (
	input  wire        clk_in,
	input  wire        resetn_in,
	input  wire [2:0]  byte_code_in,
	input  wire [2:0]  fifo_size_code_in,
	output reg  [11:0] level_out
);
	wire [11:0] step_total;
	wire        at_size;

	// (code+1)*256 covers 256 to 2048 bytes
	assign step_total = {1'b0, byte_code_in, 8'h00} + `BYTE_STEP; // RULE14
	// code 7 always equals a full fifo, so it takes the larger margin too
	assign at_size = (byte_code_in == fifo_size_code_in) || (byte_code_in == 3'h7); // RULE7

	always @(posedge clk_in) begin
		if (!resetn_in)
			level_out <= 12'h7C0;
		else if (at_size)
			level_out <= step_total - `BYTE_MARGIN_LARGE; // RULE6 RULE7
		else
			level_out <= step_total - `BYTE_MARGIN_SMALL; // RULE6
	end
endmodule // flow_threshold_calc

// ===== hdl/eth_dma_monitor.v
// monitor, overflow alert threshold and transmit notify registers of the ethernet dma controller
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "eth_dma_consts.vh"

module eth_dma_monitor (
	input  wire        clk_in,
	input  wire        resetn_in,
	input  wire [7:0]  addr_in,
	input  wire [31:0] wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [31:0] rdata_out,
	input  wire        buf_fetch_in,
	input  wire [31:0] buf_addr_in,
	input  wire        desc_fetch_in,
	input  wire [31:0] desc_addr_in,
	input  wire        writeback_done_in,
	input  wire [3:0]  rx_frame_count_in,
	input  wire [11:0] rx_byte_level_in,
	output reg         flow_request_out,
	output reg         tx_writeback_flag_out,
	output reg         irq_out
);
	reg  [31:0] buf_mon_r;
	reg  [31:0] desc_mon_r;
	reg  [2:0]  frame_thr_r;
	reg  [2:0]  byte_thr_r;
	reg         notify_dis_r;
	reg  [2:0]  size_code_r;
	reg  [1:0]  irq_stat_r;
	reg  [1:0]  irq_mask_r;
	reg  [1:0]  irq_stat_nxt;
	reg         flow_prev_r;
	reg  [31:0] rdata_nxt;
	wire [11:0] byte_level;
	wire        frame_hit;
	wire        byte_hit;
	wire        flow_nxt;
	wire        wb_event;
	wire        flow_rise;
	wire [31:0] thresh_rst;

	// reset image of the threshold register, sliced into its two fields below
	assign thresh_rst = `THRESH_RESET;

	flow_threshold_calc u_calc (
		.clk_in            (clk_in),
		.resetn_in         (resetn_in),
		.byte_code_in      (byte_thr_r),
		.fifo_size_code_in (size_code_r),
		.level_out         (byte_level)
	);

	// frame count and byte level are inputs from same-clock logic, no synchroniser
	assign frame_hit = rx_frame_count_in >= ({1'b0, frame_thr_r} + 4'h1); // RULE5
	assign byte_hit  = rx_byte_level_in >= byte_level; // RULE6
	assign flow_nxt  = frame_hit | byte_hit; // RULE8 RULE9
	assign wb_event  = writeback_done_in & ~notify_dis_r; // RULE11 RULE12
	assign flow_rise = flow_nxt & ~flow_prev_r;

	// monitors capture on fetch strobes, so they trail the live pointer
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			buf_mon_r  <= 32'h00000000; // RULE4
			desc_mon_r <= 32'h00000000; // RULE4
		end else begin
			if (buf_fetch_in)
				buf_mon_r <= buf_addr_in; // RULE1 RULE2
			if (desc_fetch_in)
				desc_mon_r <= desc_addr_in; // RULE3
		end
	end

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			frame_thr_r  <= thresh_rst[`FRAME_THR_MSB:`FRAME_THR_LSB];
			byte_thr_r   <= thresh_rst[`BYTE_THR_MSB:`BYTE_THR_LSB];
			notify_dis_r <= 1'b0;
			size_code_r  <= `FIFO_SIZE_RESET;
			irq_mask_r   <= 2'h0;
		end else if (wr_in) begin
			case (addr_in)
				`OFS_ALERT_THRESH: begin
					frame_thr_r <= wdata_in[`FRAME_THR_MSB:`FRAME_THR_LSB];
					byte_thr_r  <= wdata_in[`BYTE_THR_MSB:`BYTE_THR_LSB];
				end
				`OFS_TX_INT_SET:
					notify_dis_r <= wdata_in[`NOTIFY_DIS_BIT];
				`OFS_FIFO_SIZE:
					size_code_r <= wdata_in[2:0];
				`OFS_IRQ_MASK:
					irq_mask_r <= wdata_in[1:0];
				// monitor offsets fall through: writes ignored
				default: begin
				end // RULE4
			endcase
		end
	end

	// set wins over write-one-to-clear
	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (wr_in && addr_in == `OFS_IRQ_STATUS)
			irq_stat_nxt = irq_stat_nxt & ~wdata_in[1:0];
		if (wb_event)
			irq_stat_nxt[`IRQ_WB_BIT] = 1'b1; // RULE11
		if (flow_rise)
			irq_stat_nxt[`IRQ_FLOW_BIT] = 1'b1;
	end

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			irq_stat_r            <= 2'h0;
			flow_prev_r           <= 1'b0;
			flow_request_out      <= 1'b0;
			tx_writeback_flag_out <= 1'b0;
			irq_out               <= 1'b0;
		end else begin
			irq_stat_r            <= irq_stat_nxt;
			flow_prev_r           <= flow_nxt;
			flow_request_out      <= flow_nxt; // RULE15
			tx_writeback_flag_out <= irq_stat_nxt[`IRQ_WB_BIT]; // RULE11 RULE12
			irq_out               <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	always @* begin
		rdata_nxt = 32'h00000000; // RULE13
		case (addr_in)
			`OFS_TX_BUF_MON:   rdata_nxt = buf_mon_r;
			`OFS_TX_DESC_MON:  rdata_nxt = desc_mon_r;
			`OFS_ALERT_THRESH: rdata_nxt = {13'h0000, frame_thr_r, 13'h0000, byte_thr_r}; // RULE13
			`OFS_TX_INT_SET:   rdata_nxt = {31'h00000000, notify_dis_r}; // RULE13
			`OFS_FIFO_SIZE:    rdata_nxt = {29'h00000000, size_code_r};
			`OFS_IRQ_STATUS:   rdata_nxt = {30'h00000000, irq_stat_r};
			`OFS_IRQ_MASK:     rdata_nxt = {30'h00000000, irq_mask_r};
			default:           rdata_nxt = 32'h00000000;
		endcase
	end

	always @(posedge clk_in) begin
		if (!resetn_in)
			rdata_out <= 32'h00000000;
		else if (rd_in)
			rdata_out <= rdata_nxt;
		else
			rdata_out <= 32'h00000000;
	end
endmodule // eth_dma_monitor

// ===== testbench/eth_mac_model.sv
// mac side model holding the receive fifo fill figures
`timescale 1ns/1ps
module eth_mac_model(input wire clk_in,input wire [3:0] frames_in,input wire [11:0] bytes_in,
	output reg [3:0] count_out,output reg [11:0] level_out);
	// figures land one clock late, as from a registered fifo counter
	always @(posedge clk_in) begin
		count_out<=frames_in;
		level_out<=bytes_in;
	end
endmodule // eth_mac_model

// ===== testbench/eth_dma_monitor_properties.sv
// port assertions for the dma monitor slice
`timescale 1ns/1ps
module eth_dma_monitor_properties(input wire clk_in,resetn_in,wr_in,rd_in,buf_fetch_in,
	desc_fetch_in,writeback_done_in,flow_request_out,tx_writeback_flag_out,
	input wire [7:0] addr_in,input wire [31:0] wdata_in,rdata_out,buf_addr_in,desc_addr_in,
	input wire [3:0] rx_frame_count_in,input wire [11:0] rx_byte_level_in);
	reg [31:0] b_r,d_r,t_r;
	reg [2:0] s_r;
	reg n_r;
	wire [2:0] c=t_r[2:0];
	// a full fifo or the top code keeps a 64-byte margin
	wire [12:0] lv={c,8'h00}+13'h100-(c==3'h7||c==s_r?13'h40:13'h20);
	wire hit=rx_frame_count_in>{1'b0,t_r[18:16]}||{1'b0,rx_byte_level_in}>=lv;
	always @(posedge clk_in) begin
		if(buf_fetch_in) b_r<=buf_addr_in;
		if(desc_fetch_in) d_r<=desc_addr_in;
		if(wr_in&&addr_in==8'h08) t_r<=wdata_in&32'h70007;
		if(wr_in&&addr_in==8'h10) s_r<=wdata_in[2:0];
		if(wr_in&&addr_in==8'h0C) n_r<=wdata_in[0];
		if(!resetn_in) {b_r,d_r,t_r,s_r,n_r}<={64'h0,32'h70007,4'hE};
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	buf_mon_a: assert property(rd_in&&addr_in==8'h00|=>rdata_out==$past(b_r))
		else $error("buf monitor");
	desc_mon_a: assert property(rd_in&&addr_in==8'h04|=>rdata_out==$past(d_r))
		else $error("desc monitor");
	thr_read_a: assert property(rd_in&&addr_in==8'h08|=>rdata_out==$past(t_r))
		else $error("threshold read");
	flow_on_a: assert property(hit[*3]|=>flow_request_out) else $error("flow on");
	flow_off_a: assert property((!hit)[*3]|=>!flow_request_out) else $error("flow off");
	wb_set_a: assert property(writeback_done_in&&!n_r|=>tx_writeback_flag_out)
		else $error("wb set");
	wb_quiet_a: assert property(n_r&&!tx_writeback_flag_out|=>!tx_writeback_flag_out)
		else $error("wb quiet");
	wb_hold_a: assert property(tx_writeback_flag_out&&!(wr_in&&addr_in==8'h14&&wdata_in[0])
		|=>tx_writeback_flag_out) else $error("wb hold");
	cover property($rose(flow_request_out));
	cover property($rose(tx_writeback_flag_out));
	cover property(rd_in&&addr_in==8'h04);
endmodule // eth_dma_monitor_properties
bind eth_dma_monitor eth_dma_monitor_properties i_eth_dma_monitor_properties(.clk_in(clk_in),
	.resetn_in(resetn_in),.wr_in(wr_in),.rd_in(rd_in),.buf_fetch_in(buf_fetch_in),
	.desc_fetch_in(desc_fetch_in),.writeback_done_in(writeback_done_in),.addr_in(addr_in),
	.flow_request_out(flow_request_out),.tx_writeback_flag_out(tx_writeback_flag_out),
	.wdata_in(wdata_in),.rdata_out(rdata_out),.buf_addr_in(buf_addr_in),.desc_addr_in(desc_addr_in),
	.rx_frame_count_in(rx_frame_count_in),.rx_byte_level_in(rx_byte_level_in));

// ===== testbench/eth_dma_monitor_test.sv
// self-checking bench for the dma monitor slice
`timescale 1ns/1ps
module eth_dma_monitor_test;
	reg clk_in=0,resetn_in=0,wr_in=0,rd_in=0,bf=0,df=0,wb=0;
	reg [7:0] addr_in=8'h00;
	reg [31:0] wdata_in=32'h0,ba=32'h0,da=32'h0;
	reg [3:0] fc=4'h0;
	reg [11:0] bl=12'h000;
	wire [3:0] cnt;
	wire [11:0] lvl;
	wire [31:0] rdata_out;
	wire fl,tw,irq_out;
	integer mismatches=0,n_compared=0,cyc=0;
	always #12.5 clk_in=~clk_in;
	eth_mac_model i_eth_mac_model(.clk_in(clk_in),.frames_in(fc),.bytes_in(bl),.count_out(cnt),
		.level_out(lvl));
	eth_dma_monitor i_eth_dma_monitor(.clk_in(clk_in),.resetn_in(resetn_in),.addr_in(addr_in),
		.wdata_in(wdata_in),.wr_in(wr_in),.rd_in(rd_in),.rdata_out(rdata_out),.buf_fetch_in(bf),
		.buf_addr_in(ba),.desc_fetch_in(df),.desc_addr_in(da),.writeback_done_in(wb),
		.rx_frame_count_in(cnt),.rx_byte_level_in(lvl),.flow_request_out(fl),
		.tx_writeback_flag_out(tw),.irq_out(irq_out));
	task chk(input [39:0] nm,input [31:0] e,s); begin
		n_compared=n_compared+1;
		if(e!==s) begin
			mismatches=mismatches+1;
			$display("Error %0s exp %h got %h",nm,e,s);
		end
	end endtask
	task w(input [7:0] a,input [31:0] d); begin
		@(posedge clk_in) {addr_in,wdata_in,wr_in}<={a,d,1'b1};
		@(posedge clk_in) wr_in<=0;
	end endtask
	task r(input [7:0] a,input [31:0] e); begin
		@(posedge clk_in) {addr_in,rd_in}<={a,1'b1};
		@(posedge clk_in) rd_in<=0;
		#1 chk("rdata",e,rdata_out);
	end endtask
	// mac fill changes pass the model register and the flow register
	task f(input [3:0] n,input [11:0] b,input e); begin
		{fc,bl}<={n,b};
		repeat(4) @(posedge clk_in);
		#1 chk("flow",{31'h0,e},{31'h0,fl});
	end endtask
	task pw; begin
		@(posedge clk_in) wb<=1;
		@(posedge clk_in) wb<=0;
		#1;
	end endtask
	task t_mon; begin
		r(8'h00,32'h0);
		r(8'h04,32'h0);
		@(posedge clk_in) {bf,df,ba,da}<={2'h3,64'hA5A50F0F00001230};
		@(posedge clk_in) {bf,df}<=2'h0;
		w(8'h00,32'hFFFFFFFF);
		w(8'h04,32'hFFFFFFFF);
		r(8'h00,32'hA5A50F0F);
		r(8'h04,32'h1230);
		r(8'h40,32'h0);
	end endtask
	task t_thr; begin
		r(8'h08,32'h70007);
		w(8'h08,32'h00070000);
		r(8'h08,32'h70000);
		w(8'h08,32'h0);
		f(4'h0,12'h0DF,1'h0);
		f(4'h0,12'h0E0,1'h1);
		f(4'h1,12'h000,1'h1);
		f(4'h0,12'h000,1'h0);
		w(8'h08,32'h70007);
		f(4'h7,12'h7BF,1'h0);
		f(4'h8,12'h000,1'h1);
		f(4'h0,12'h7C0,1'h1);
		w(8'h10,32'h3);
		w(8'h08,32'h3);
		f(4'h0,12'h3BF,1'h0);
		f(4'h0,12'h3C0,1'h1);
	end endtask
	task t_wb; begin
		pw;
		chk("flag",32'h1,tw);
		chk("irq",32'h0,irq_out);
		w(8'h18,32'h1);
		@(posedge clk_in) #1 chk("irq",32'h1,irq_out);
		w(8'h14,32'h1);
		@(posedge clk_in) #1 chk("flag",32'h0,tw);
		chk("irq",32'h0,irq_out);
		w(8'h0C,32'h00000001);
		r(8'h0C,32'h1);
		pw;
		chk("flag",32'h0,tw);
		r(8'h14,32'h2);
	end endtask
	task test_done; begin
		$display("compared %0d mismatches %0d",n_compared,mismatches);
		if(mismatches==0&&n_compared>0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	end endtask
	always @(posedge clk_in) begin
		cyc=cyc+1;
		if(cyc==2000) begin
			mismatches=mismatches+1;
			test_done;
		end
	end
	initial begin
		repeat(20) @(posedge clk_in);
		resetn_in<=1;
		t_mon;
		t_thr;
		t_wb;
		test_done;
	end
endmodule // eth_dma_monitor_test
